// File: include/cafm_pkg.sv
package cafm_pkg;

    // Array sizes.
    localparam int NUM_FILTERS = 16;
    localparam int NUM_MASKS   = 3;
    localparam int NUM_BUFPNT  = 4;
    localparam int NUM_MSKSEL  = 2;

    // Byte addresses of the register map.
    localparam logic [11:0] FSID_BASE   = 12'h000;
    localparam logic [11:0] FEID_BASE   = 12'h040;
    localparam logic [11:0] MSID_BASE   = 12'h080;
    localparam logic [11:0] MEID_BASE   = 12'h090;
    localparam logic [11:0] MSKSEL_LO   = 12'h0a0;
    localparam logic [11:0] MSKSEL_HI   = 12'h0a4;
    localparam logic [11:0] FEN_ADDR    = 12'h0a8;
    localparam logic [11:0] BUFPNT_BASE = 12'h0b0;
    localparam logic [11:0] STATUS_ADDR = 12'h0c0;

    // Field positions inside the first identifier word.
    localparam int SID_MSB     = 15;
    localparam int SID_LSB     = 5;
    localparam int EXT_SEL_BIT = 3;
    localparam int EIDH_MSB    = 1;
    localparam int EIDH_LSB    = 0;

    // Implemented bits of the first identifier word; bits 4 and 2 read zero.
    localparam logic [15:0] SID_WORD_IMPL = 16'hffeb;

    // Reset values.
    localparam logic [15:0] ID_WORD_RST = 16'h0000;
    localparam logic [15:0] MSKSEL_RST  = 16'h0000;
    localparam logic [15:0] FEN_RST     = 16'hffff;
    localparam logic [15:0] BUFPNT_RST  = 16'h0000;

    // Mask source encodings.
    localparam logic [1:0] MSRC_MASK0 = 2'h0;
    localparam logic [1:0] MSRC_MASK1 = 2'h1;
    localparam logic [1:0] MSRC_MASK2 = 2'h2;
    localparam logic [1:0] MSRC_RSVD  = 2'h3;

    // Buffer pointer value that routes to the receive FIFO.
    localparam logic [3:0] PTR_FIFO = 4'hf;

    // Received identifier from the protocol engine.
    typedef struct packed {
        logic [10:0] standard_identifier_bits;
        logic [17:0] extended_identifier;
        logic        extended_frame;
    } cafm_rx_id_s;

    // Result of one filtering decision.
    typedef struct packed {
        logic       hit;
        logic [3:0] filter_index;
        logic [3:0] filter_buffer_pointer;
        logic       to_fifo;
    } cafm_result_s;

endpackage : cafm_pkg

// File: logic/cafm_filter.sv
// Function
// - Sixteen writable filters with standard and extended words.
// - Three masks with standard and extended words.
// - Filter bits 15:5 give standard identifier value.
// - Bits 1:0 hold extended identifier bits 17:16.
// - Second word holds extended identifier bits 15:0.
// - Type enable set: frame format must match select.
// - Type enable clear: either format accepted.
// - Standard mask bit one compares, zero ignores.
// - Extended mask bits likewise compare or ignore.
// - Two-bit mask source picks mask; 11 reserved.
// - Mask source words hold 2k+1:2k, reset zero.
// - Bits 4 and 2 unimplemented, read zero.
// - Per-filter enables gate acceptance; reset all set.
// - Hit routes to buffer by pointer; 1111 FIFO.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps

module cafm_filter (
    // Clock and reset.
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    // APB slave.
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    input  wire logic [3:0]           pstrb_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // Received identifiers from the protocol engine.
    input  wire logic                 rx_valid_i,
    input  wire cafm_pkg::cafm_rx_id_s rx_id_i,
    // Filtering result.
    output logic                      result_valid_o,
    output cafm_pkg::cafm_result_s    result_o
);

    // Register storage.
    logic [15:0] fsid_q   [cafm_pkg::NUM_FILTERS];
    logic [15:0] feid_q   [cafm_pkg::NUM_FILTERS];
    logic [15:0] msid_q   [cafm_pkg::NUM_MASKS];
    logic [15:0] meid_q   [cafm_pkg::NUM_MASKS];
    logic [15:0] msksel_q [cafm_pkg::NUM_MSKSEL];
    logic [15:0] bufpnt_q [cafm_pkg::NUM_BUFPNT];
    logic [15:0] fen_q;

    // Bus decode.
    logic        wr_en;
    logic        addr_ok;
    logic [3:0]  word_idx;
    logic        in_fsid;
    logic        in_feid;
    logic        in_msid;
    logic        in_meid;
    logic        in_bufpnt;
    logic        in_msksel;
    logic [15:0] wdata16;
    logic [15:0] lane_mask;
    logic        in_fen;
    logic        in_status;
    logic        rd_setup;

    // Read path.
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;
    logic [9:0]  status_word;

    // Match logic.
    logic [cafm_pkg::NUM_FILTERS-1:0] hit_vec;
    logic [63:0]                      ptr_flat;
    cafm_pkg::cafm_result_s           result_d;
    cafm_pkg::cafm_result_s           result_q;
    logic                             result_valid_q;

    // The slave answers in the access phase without wait states.
    assign pready_o = 1'b1;

    assign wr_en    = psel_i & penable_i & pwrite_i;
    assign word_idx = paddr_i[5:2];
    assign wdata16  = pwdata_i[15:0];
    assign lane_mask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

    assign in_fsid   = (paddr_i[11:6] == cafm_pkg::FSID_BASE[11:6]);
    assign in_feid   = (paddr_i[11:6] == cafm_pkg::FEID_BASE[11:6]);
    assign in_msid   = (paddr_i[11:4] == cafm_pkg::MSID_BASE[11:4])
                       && (paddr_i[3:2] != 2'h3);
    assign in_meid   = (paddr_i[11:4] == cafm_pkg::MEID_BASE[11:4])
                       && (paddr_i[3:2] != 2'h3);
    assign in_bufpnt = (paddr_i[11:4] == cafm_pkg::BUFPNT_BASE[11:4]);
    assign in_msksel = (paddr_i == cafm_pkg::MSKSEL_LO)
                       || (paddr_i == cafm_pkg::MSKSEL_HI);
    assign in_fen    = (paddr_i == cafm_pkg::FEN_ADDR);
    assign in_status = (paddr_i == cafm_pkg::STATUS_ADDR);

    // Address check; the status word is read only and misaligned words are refused.
    always_comb begin
        addr_ok = 1'b0;
        if (paddr_i[1:0] == 2'h0) begin
            if (in_fsid || in_feid || in_msid || in_meid || in_bufpnt || in_msksel) begin
                addr_ok = 1'b1;
            end else if (in_fen) begin
                addr_ok = 1'b1;
            end else if (in_status) begin
                addr_ok = ~pwrite_i;
            end else begin
                addr_ok = 1'b0;
            end
        end
    end

    assign pslverr_o = psel_i & penable_i & ~addr_ok;

    // Merges written byte lanes into a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [15:0] lanes);
        merge16 = (old_v & ~lanes) | (new_v & lanes);
    endfunction : merge16

    // Filter words, one pair per filter.
    genvar gf;
    generate
        for (gf = 0; gf < cafm_pkg::NUM_FILTERS; gf++) begin : g_filt
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    fsid_q[gf] <= cafm_pkg::ID_WORD_RST;
                end else if (wr_en && in_fsid && (word_idx == 4'(gf))) begin
                    fsid_q[gf] <= merge16(fsid_q[gf], wdata16, lane_mask)
                                  & cafm_pkg::SID_WORD_IMPL;
                end
            end

            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    feid_q[gf] <= cafm_pkg::ID_WORD_RST;
                end else if (wr_en && in_feid && (word_idx == 4'(gf))) begin
                    feid_q[gf] <= merge16(feid_q[gf], wdata16, lane_mask);
                end
            end
        end
    endgenerate

    // Mask words, one pair per mask.
    genvar gm;
    generate
        for (gm = 0; gm < cafm_pkg::NUM_MASKS; gm++) begin : g_mask
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    msid_q[gm] <= cafm_pkg::ID_WORD_RST;
                end else if (wr_en && in_msid && (paddr_i[3:2] == 2'(gm))) begin
                    msid_q[gm] <= merge16(msid_q[gm], wdata16, lane_mask)
                                  & cafm_pkg::SID_WORD_IMPL;
                end
            end

            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meid_q[gm] <= cafm_pkg::ID_WORD_RST;
                end else if (wr_en && in_meid && (paddr_i[3:2] == 2'(gm))) begin
                    meid_q[gm] <= merge16(meid_q[gm], wdata16, lane_mask);
                end
            end
        end
    endgenerate

    // Mask source words.
    genvar gs;
    generate
        for (gs = 0; gs < cafm_pkg::NUM_MSKSEL; gs++) begin : g_msksel
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    msksel_q[gs] <= cafm_pkg::MSKSEL_RST;
                end else if (wr_en && in_msksel && (paddr_i[2] == 1'(gs))) begin
                    msksel_q[gs] <= merge16(msksel_q[gs], wdata16, lane_mask);
                end
            end
        end
    endgenerate

    // Buffer pointer words, four filters per word.
    genvar gb;
    generate
        for (gb = 0; gb < cafm_pkg::NUM_BUFPNT; gb++) begin : g_bufpnt
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    bufpnt_q[gb] <= cafm_pkg::BUFPNT_RST;
                end else if (wr_en && in_bufpnt && (paddr_i[3:2] == 2'(gb))) begin
                    bufpnt_q[gb] <= merge16(bufpnt_q[gb], wdata16, lane_mask);
                end
            end
            assign ptr_flat[gb*16 +: 16] = bufpnt_q[gb];
        end
    endgenerate

    // Filter enables.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fen_q <= cafm_pkg::FEN_RST;
        end else if (wr_en && in_fen) begin
            fen_q <= merge16(fen_q, wdata16, lane_mask);
        end
    end

    // Per-filter comparison against the selected mask.
    genvar gk;
    generate
        for (gk = 0; gk < cafm_pkg::NUM_FILTERS; gk++) begin : g_match
            localparam int SEL_WORD = gk / 8;
            localparam int SEL_LSB  = (gk % 8) * 2;
            logic [1:0]  msel;
            logic [15:0] m_sid;
            logic [15:0] m_eid;
            logic        m_ok;
            logic [10:0] sid_diff;
            logic [17:0] eid_diff;
            logic        sid_ok;
            logic        eid_ok;
            logic        type_ok;

            assign msel = msksel_q[SEL_WORD][SEL_LSB +: 2];

            always_comb begin
                m_sid = msid_q[0];
                m_eid = meid_q[0];
                m_ok  = 1'b1;
                case (msel)
                    cafm_pkg::MSRC_MASK0: begin
                        m_sid = msid_q[0];
                        m_eid = meid_q[0];
                    end
                    cafm_pkg::MSRC_MASK1: begin
                        m_sid = msid_q[1];
                        m_eid = meid_q[1];
                    end
                    cafm_pkg::MSRC_MASK2: begin
                        m_sid = msid_q[2];
                        m_eid = meid_q[2];
                    end
                    default: begin
                        m_ok = 1'b0;
                    end
                endcase
            end

            // Differences count only where the mask includes the bit.
            assign sid_diff = (fsid_q[gk][cafm_pkg::SID_MSB:cafm_pkg::SID_LSB]
                               ^ rx_id_i.standard_identifier_bits)
                              & m_sid[cafm_pkg::SID_MSB:cafm_pkg::SID_LSB];
            assign eid_diff = ({fsid_q[gk][cafm_pkg::EIDH_MSB:cafm_pkg::EIDH_LSB], feid_q[gk]}
                               ^ rx_id_i.extended_identifier)
                              & {m_sid[cafm_pkg::EIDH_MSB:cafm_pkg::EIDH_LSB], m_eid};

            assign sid_ok = (sid_diff == 11'h000);
            // A standard frame carries no extended bits, so only the standard part compares.
            assign eid_ok = ~rx_id_i.extended_frame | (eid_diff == 18'h00000);

            assign type_ok = ~m_sid[cafm_pkg::EXT_SEL_BIT]
                             | (fsid_q[gk][cafm_pkg::EXT_SEL_BIT]
                                == rx_id_i.extended_frame);

            assign hit_vec[gk] = fen_q[gk] & m_ok & sid_ok & eid_ok & type_ok;
        end
    endgenerate

    // The lowest-numbered hitting filter wins.
    always_comb begin
        result_d = '0;
        for (int i = cafm_pkg::NUM_FILTERS - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                result_d.hit                   = 1'b1;
                result_d.filter_index          = 4'(i);
                result_d.filter_buffer_pointer = ptr_flat[i*4 +: 4];
                result_d.to_fifo               = (ptr_flat[i*4 +: 4] == cafm_pkg::PTR_FIFO);
            end
        end
    end

    // Result registers.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_valid_q <= 1'b0;
        end else begin
            result_valid_q <= rx_valid_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_q <= '0;
        end else if (rx_valid_i) begin
            result_q <= result_d;
        end
    end

    assign result_valid_o = result_valid_q;
    assign result_o       = result_q;

    // Status word of the last filtering decision.
    assign status_word = {result_q.to_fifo, result_q.filter_buffer_pointer,
                          result_q.filter_index, result_q.hit};

    // Read data; unmapped words read zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (addr_ok && !pwrite_i) begin
            if (in_fsid) begin
                rdata_d[15:0] = fsid_q[word_idx];
            end else if (in_feid) begin
                rdata_d[15:0] = feid_q[word_idx];
            end else if (in_msid) begin
                rdata_d[15:0] = msid_q[paddr_i[3:2]];
            end else if (in_meid) begin
                rdata_d[15:0] = meid_q[paddr_i[3:2]];
            end else if (in_bufpnt) begin
                rdata_d[15:0] = bufpnt_q[paddr_i[3:2]];
            end else if (in_msksel) begin
                rdata_d[15:0] = msksel_q[paddr_i[2]];
            end else if (in_fen) begin
                rdata_d[15:0] = fen_q;
            end else begin
                rdata_d[9:0] = status_word;
            end
        end
    end

    // Read data is taken in the setup phase, so it leaves a flip-flop and
    // stands unchanged for the whole access phase without a wait state.
    assign rd_setup = psel_i & ~penable_i;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= rdata_d;
        end
    end

    assign prdata_o = prdata_q;

endmodule : cafm_filter

// File: sim/cafm_filter_properties.sv
`timescale 1ns/1ps

module cafm_filter_properties (
    // Clock and reset.
    input wire logic                   ref_clk_i,
    input wire logic                   rst_n_i,
    // APB slave.
    input wire logic                   psel_i,
    input wire logic                   penable_i,
    input wire logic                   pwrite_i,
    input wire logic [11:0]            paddr_i,
    input wire logic [31:0]            prdata_o,
    input wire logic                   pready_o,
    input wire logic                   pslverr_o,
    // Receive side.
    input wire logic                   rx_valid_i,
    input wire logic                   result_valid_o,
    input wire cafm_pkg::cafm_result_s result_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic rd_acc;
    assign rd_acc = psel_i && penable_i && !pwrite_i;

    property p_res_pulse;
        rx_valid_i |=> result_valid_o;
    endproperty
    property p_res_quiet;
        !rx_valid_i |=> !result_valid_o;
    endproperty
    property p_res_hold;
        !rx_valid_i |=> $stable(result_o);
    endproperty
    property p_fifo;
        result_valid_o && result_o.hit
            |-> result_o.to_fifo == (result_o.filter_buffer_pointer == 4'hf);
    endproperty
    property p_ready;
        psel_i && penable_i |-> pready_o;
    endproperty
    property p_upper;
        rd_acc |-> prdata_o[31:16] == 16'h0000;
    endproperty
    property p_fgap;
        rd_acc && paddr_i < 12'h040 |-> !prdata_o[4] && !prdata_o[2];
    endproperty
    property p_mgap;
        rd_acc && paddr_i inside {12'h080, 12'h084, 12'h088} |-> !prdata_o[4] && !prdata_o[2];
    endproperty
    property p_hole;
        psel_i && penable_i && paddr_i == 12'h08c |-> pslverr_o;
    endproperty
    property p_align;
        psel_i && penable_i && paddr_i[1:0] != 2'h0 |-> pslverr_o;
    endproperty

    a_res_pulse: assert property (p_res_pulse) else $error("result missing");
    a_res_quiet: assert property (p_res_quiet) else $error("stray result");
    a_res_hold: assert property (p_res_hold) else $error("result moved");
    a_fifo: assert property (p_fifo) else $error("fifo routing wrong");
    a_ready: assert property (p_ready) else $error("no ready");
    a_upper: assert property (p_upper) else $error("upper read bits set");
    a_fgap: assert property (p_fgap) else $error("filter gap bits set");
    a_mgap: assert property (p_mgap) else $error("mask gap bits set");
    a_hole: assert property (p_hole) else $error("hole accepted");
    a_align: assert property (p_align) else $error("misaligned accepted");

    c_hit: cover property (result_valid_o && result_o.hit);
    c_fifo: cover property (result_valid_o && result_o.to_fifo);
    c_err: cover property (psel_i && penable_i && pslverr_o);
endmodule : cafm_filter_properties

bind cafm_filter cafm_filter_properties u_props (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i), .result_valid_o(result_valid_o),
    .result_o(result_o));

// File: sim/cafm_rx_engine.sv
`timescale 1ns/1ps

module cafm_rx_engine (
    // Clock.
    input  wire logic             ref_clk_i,
    // Identifier delivery.
    output logic                  rx_valid_o,
    output cafm_pkg::cafm_rx_id_s rx_id_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_id_o    = '0;
    end

    // Between frames the identifier lines carry the inverse of the last one.
    task automatic send(input cafm_pkg::cafm_rx_id_s id, input int gap);
        repeat (gap) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        rx_valid_o <= 1'b1;
        rx_id_o    <= id;
        @(posedge ref_clk_i);
        rx_valid_o <= 1'b0;
        rx_id_o    <= ~id;
    endtask : send
endmodule : cafm_rx_engine

// File: sim/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0]  pstrb_i = 4'h0;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, rx_valid_i, result_valid_o;
    cafm_pkg::cafm_rx_id_s  rx_id_i;
    cafm_pkg::cafm_result_s result_o;
    int          n_fail = 0;
    int          total_checks = 0;
    int          gap = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    cafm_filter uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i), .result_valid_o(result_valid_o),
        .result_o(result_o));
    cafm_rx_engine eng (.ref_clk_i(ref_clk_i), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        total_checks++;
        if (got !== x) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, x, got);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] x, input logic ee);
        int n;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= {4{w}};
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (pready_o !== 1'b1) begin
            n_fail++;
            wrap_up();
        end
        chk($sformatf("error %h", a), {31'h0, ee}, {31'h0, pslverr_o});
        if (!w) chk($sformatf("data %h", a), x, prdata_o);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : acc

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        acc(1'b0, a, 32'h0, x, 1'b0);
    endtask : rd

    task automatic rx(input logic [10:0] sid, input logic [17:0] eid, input logic ext,
                      input logic hit, input logic [3:0] idx, input logic [3:0] ptr);
        eng.send({sid, eid, ext}, gap);
        #1;
        chk("result valid", 32'h1, {31'h0, result_valid_o});
        if (hit) chk("result", {22'h0, 1'b1, idx, ptr, ptr == 4'hf}, {22'h0, result_o});
        else chk("hit", 32'h0, {31'h0, result_o.hit});
    endtask : rx

    initial begin
        #500us;
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(12'h0a0, 32'h0);
        rd(12'h0a4, 32'h0);
        rd(12'h0a8, 32'hffff);
        $display("test reset done");
        for (int n = 0; n < 16; n++) begin
            wr(12'(4 * n), 32'hffff);
            wr(12'(12'h040 + 4 * n), 32'(16'ha5c0 + n));
            rd(12'(4 * n), 32'hffeb);
            rd(12'(12'h040 + 4 * n), 32'(16'ha5c0 + n));
        end
        for (int m = 0; m < 3; m++) begin
            wr(12'(12'h080 + 4 * m), 32'hffff);
            wr(12'(12'h090 + 4 * m), 32'(16'h3c00 + m));
            rd(12'(12'h080 + 4 * m), 32'hffeb);
            rd(12'(12'h090 + 4 * m), 32'(16'h3c00 + m));
        end
        acc(1'b0, 12'h08c, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 12'h09c, 32'h0, 32'h0, 1'b1);
        acc(1'b1, 12'h0a2, 32'hffff, 32'h0, 1'b1);
        rd(12'h0a0, 32'h0);
        wr(12'h0a4, 32'hc3a5);
        rd(12'h0a4, 32'hc3a5);
        $display("test registers done");
        wr(12'h0a8, 32'h0008);
        wr(12'h0a0, 32'h0);
        wr(12'h00c, 32'h2462);
        wr(12'h04c, 32'habcd);
        wr(12'h080, 32'hffe0);
        wr(12'h0b0, 32'h5000);
        rx(11'h123, 18'h0, 1'b0, 1'b1, 4'h3, 4'h5);
        rx(11'h122, 18'h0, 1'b0, 1'b0, 4'h0, 4'h0);
        rx(11'h123, 18'h3ebff, 1'b1, 1'b1, 4'h3, 4'h5);
        wr(12'h080, 32'hffc0);
        rx(11'h122, 18'h0, 1'b0, 1'b1, 4'h3, 4'h5);
        wr(12'h080, 32'hffe3);
        wr(12'h090, 32'hffff);
        rx(11'h123, 18'h2abcd, 1'b1, 1'b1, 4'h3, 4'h5);
        rx(11'h123, 18'h3abcd, 1'b1, 1'b0, 4'h0, 4'h0);
        rx(11'h123, 18'h2abcc, 1'b1, 1'b0, 4'h0, 4'h0);
        wr(12'h090, 32'hfffe);
        rx(11'h123, 18'h2abcc, 1'b1, 1'b1, 4'h3, 4'h5);
        $display("test identifier match done");
        gap = 3;
        wr(12'h080, 32'hffeb);
        rx(11'h123, 18'h2abcd, 1'b1, 1'b0, 4'h0, 4'h0);
        rx(11'h123, 18'h0, 1'b0, 1'b1, 4'h3, 4'h5);
        wr(12'h00c, 32'h246a);
        rx(11'h123, 18'h0, 1'b0, 1'b0, 4'h0, 4'h0);
        rx(11'h123, 18'h2abcd, 1'b1, 1'b1, 4'h3, 4'h5);
        wr(12'h080, 32'hffe3);
        rx(11'h123, 18'h0, 1'b0, 1'b1, 4'h3, 4'h5);
        rx(11'h123, 18'h2abcd, 1'b1, 1'b1, 4'h3, 4'h5);
        $display("test frame type done");
        wr(12'h084, 32'h0);
        wr(12'h088, 32'hffe0);
        for (int s = 0; s < 4; s++) begin
            wr(12'h0a0, 32'(s << 6));
            rx(11'h7ff, 18'h0, 1'b0, s == 1, 4'h3, 4'h5);
        end
        $display("test mask source done");
        wr(12'h0a0, 32'h0);
        wr(12'h0a4, 32'h0);
        wr(12'h034, 32'h2462);
        wr(12'h0bc, 32'h00f0);
        wr(12'h0a8, 32'h2008);
        rx(11'h123, 18'h0, 1'b0, 1'b1, 4'h3, 4'h5);
        wr(12'h0a4, 32'h0400);
        rx(11'h7ff, 18'h0, 1'b0, 1'b1, 4'hd, 4'hf);
        wr(12'h0a8, 32'h2000);
        rx(11'h123, 18'h0, 1'b0, 1'b1, 4'hd, 4'hf);
        rd(12'h0c0, 32'h03fb);
        acc(1'b1, 12'h0c0, 32'h0, 32'h0, 1'b1);
        wr(12'h0a8, 32'h0);
        rx(11'h123, 18'h0, 1'b0, 1'b0, 4'h0, 4'h0);
        $display("test enable and routing done");
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(12'h0a4, 32'h0);
        rd(12'h0a8, 32'hffff);
        rd(12'h0c0, 32'h0);
        $display("test second reset done");
        wrap_up();
    end
endmodule : tb_top
